// File: sfxr_defs.svh
`ifndef SFXR_DEFS_SVH
`define SFXR_DEFS_SVH
// Exit and recovery frame lengths, in serial clocks
`define SFXR_FRAME_0       6'd7
`define SFXR_FRAME_1       6'd9
`define SFXR_FRAME_2       6'd13
`define SFXR_FRAME_3       6'd17
`define SFXR_FRAME_4       6'd25
`define SFXR_FRAME_5       6'd33
`define SFXR_FRAME_COUNT   3'd6
`define SFXR_FF_CLOCKS     6'd8
// Commands
`define SFXR_CMD_RST_EN    8'h66
`define SFXR_CMD_RST_MEM   8'h99
`define SFXR_CMD_RD_FLAG   8'h70
`define SFXR_FLAG_READY    7
// Timing
`define SFXR_SYS_MHZ       50
`define SFXR_PWRUP_US      150
`define SFXR_PWRUP_CYC     (`SFXR_PWRUP_US * `SFXR_SYS_MHZ)
`define SFXR_DESEL_NS      50
`define SFXR_DESEL_CYC     ((`SFXR_DESEL_NS + 19) / 20)
`define SFXR_RST_NS        50
`define SFXR_RST_CYC       ((`SFXR_RST_NS + 19) / 20)
`endif

// File: sfxr_pkg.sv
package sfxr_pkg;
  typedef enum logic [1:0] {
    SFXR_OP_XIP_EXIT = 2'h0,
    SFXR_OP_RECOVER  = 2'h1,
    SFXR_OP_POLL     = 2'h2,
    SFXR_OP_HW_RESET = 2'h3
  } sfxr_op_type;

  typedef struct packed {
    logic        valid;
    sfxr_op_type op;
  } sfxr_req_type;

  typedef struct packed {
    logic busy;
    logic done;
    logic ready;
    logic pwr_ok;
  } sfxr_stat_type;

  typedef struct packed {
    logic       sel_n;
    logic [3:0] dq_o;
    logic [3:0] dq_oe;
    logic       rst_n;
  } sfxr_pins_type;
endpackage

// File: sfxr_ctrl.sv
// Functional notes
// - Data line zero during first dummy clock is the confirmation bit.
// - Hardware reset pulse is given only while the device is deselected.
// - Forced exit uses frames of 7,9,13,17,25,33 clocks, confirmation bit 1.
// - After forced exit, send reset-enable then reset-memory.
// - Device stays deselected through power-up and power-down.
// - Completion needs two flag reads, both with controller bit 1.
// - Wait 150 us after supply minimum before relying on all commands.
// - Recovery runs pulse-sequence part first, then protocol-exit part.
// - Recovery part one holds lines zero and three high through the frames.
// - Recovery part two holds lines zero and three high for 8 clocks.
// - Afterwards rewrite the nonvolatile configuration register; the controller sends no register write.
`timescale 1ns/10ps
`include "sfxr_defs.svh"
module sfxr_ctrl #(
  parameter int PWRUP_CYC = `SFXR_PWRUP_CYC
) (
  // System
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // Link clock
  input  wire logic                   link_clk,
  // User orders
  input  wire sfxr_pkg::sfxr_req_type req,
  output      logic                   req_ready,
  output      sfxr_pkg::sfxr_stat_type stat,
  // Flash pins
  output      sfxr_pkg::sfxr_pins_type pins,
  output      logic                   sclk_en,
  input  wire logic                   dq1_in
);
  typedef enum logic [3:0] {
    S_PWRUP, S_IDLE, S_DESEL, S_FRAME, S_RST_LO, S_CMD, S_READ, S_DONE
  } sfxr_state_type;

  sfxr_state_type        st_r, st_nxt;
  sfxr_pkg::sfxr_op_type op_r, op_nxt;
  logic [12:0] wait_r, wait_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic [1:0]  phase_r, phase_nxt;
  logic        ok_r, ok_nxt;
  logic        done_r, done_nxt;
  logic        pwr_ok_r, pwr_ok_nxt;
  logic        go_tgl_r, go_tgl_nxt;
  logic        rst_pin_r, rst_pin_nxt;
  logic [5:0]  frame_len;
  logic [7:0]  cmd_byte;
  logic        sys_rst_sync0_r, sys_rst_sync1_r;

  // Link side: runs one frame of len clocks with given byte or all-ones
  logic [5:0]  lk_len_r, lk_len_nxt;
  logic [7:0]  lk_byte_r, lk_byte_nxt;
  logic        lk_ones_r, lk_ones_nxt;
  logic        lk_go_s0_r, lk_go_s1_r, lk_go_s2_r;
  logic [5:0]  lk_cnt_r, lk_cnt_nxt;
  logic        lk_run_r, lk_run_nxt;
  logic        lk_act_r, lk_act_nxt;
  logic        lk_done_tgl_r, lk_done_tgl_nxt;
  logic [7:0]  lk_shift_r, lk_shift_nxt;
  logic        lk_d1_s0_r, lk_d1_s1_r;
  logic        dn_s0_r, dn_s1_r, dn_s2_r;
  logic [7:0]  rd_byte;

  always_comb begin
    unique case (idx_r)
      3'd0: frame_len = `SFXR_FRAME_0;
      3'd1: frame_len = `SFXR_FRAME_1;
      3'd2: frame_len = `SFXR_FRAME_2;
      3'd3: frame_len = `SFXR_FRAME_3;
      3'd4: frame_len = `SFXR_FRAME_4;
      default: frame_len = `SFXR_FRAME_5;
    endcase
  end

  always_comb begin
    cmd_byte = `SFXR_CMD_RD_FLAG;
    if (op_r == sfxr_pkg::SFXR_OP_XIP_EXIT) begin
      cmd_byte = (phase_r == 2'd1) ? `SFXR_CMD_RST_EN : `SFXR_CMD_RST_MEM;
    end
  end

  always_comb begin
    st_nxt     = st_r;
    op_nxt     = op_r;
    wait_nxt   = (wait_r != 13'd0) ? wait_r - 13'd1 : 13'd0;
    idx_nxt    = idx_r;
    phase_nxt  = phase_r;
    ok_nxt     = ok_r;
    done_nxt   = 1'b0;
    pwr_ok_nxt = pwr_ok_r;
    go_tgl_nxt = go_tgl_r;
    unique case (st_r)
      S_PWRUP: begin
        if (wait_r == 13'd0) begin
          pwr_ok_nxt = 1'b1;
          st_nxt     = S_IDLE;
        end
      end
      S_IDLE: begin
        if (req.valid) begin
          op_nxt    = req.op;
          idx_nxt   = 3'd0;
          phase_nxt = 2'd0;
          ok_nxt    = 1'b1;
          wait_nxt  = 13'(`SFXR_DESEL_CYC);
          st_nxt    = S_DESEL;
        end
      end
      S_DESEL: begin
        if (wait_r == 13'd0) begin
          if (op_r == sfxr_pkg::SFXR_OP_HW_RESET) begin
            wait_nxt = 13'(`SFXR_RST_CYC);
            st_nxt   = S_RST_LO;
          end else begin
            go_tgl_nxt = ~go_tgl_r;
            st_nxt     = S_FRAME;
          end
        end
      end
      S_RST_LO: begin
        if (wait_r == 13'd0) begin
          st_nxt = S_DONE;
        end
      end
      S_FRAME: begin
        if (dn_s2_r != dn_s1_r) begin
          wait_nxt = 13'(`SFXR_DESEL_CYC);
          st_nxt   = S_DESEL;
          if (op_r == sfxr_pkg::SFXR_OP_POLL) begin
            if (!rd_byte[`SFXR_FLAG_READY]) ok_nxt = 1'b0;
            phase_nxt = phase_r + 2'd1;
            if (phase_r == 2'd1) st_nxt = S_DONE;
          end else if (phase_r == 2'd0) begin
            if (idx_r == `SFXR_FRAME_COUNT - 3'd1) begin
              phase_nxt = 2'd1;
            end else begin
              idx_nxt = idx_r + 3'd1;
            end
          end else if (op_r == sfxr_pkg::SFXR_OP_RECOVER || phase_r == 2'd2) begin
            st_nxt = S_DONE;
          end else begin
            phase_nxt = 2'd2;
          end
        end
      end
      S_DONE: begin
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
    // Registered so the reset pin cannot glitch on a state change
    rst_pin_nxt = (st_nxt != S_RST_LO);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r     <= S_PWRUP;
      op_r     <= sfxr_pkg::SFXR_OP_XIP_EXIT;
      wait_r   <= 13'(PWRUP_CYC);
      idx_r    <= 3'd0;
      phase_r  <= 2'd0;
      ok_r     <= 1'b0;
      done_r   <= 1'b0;
      pwr_ok_r <= 1'b0;
      go_tgl_r <= 1'b0;
      rst_pin_r <= 1'b1;
    end else begin
      st_r     <= st_nxt;
      op_r     <= op_nxt;
      wait_r   <= wait_nxt;
      idx_r    <= idx_nxt;
      phase_r  <= phase_nxt;
      ok_r     <= ok_nxt;
      done_r   <= done_nxt;
      pwr_ok_r <= pwr_ok_nxt;
      go_tgl_r <= go_tgl_nxt;
      rst_pin_r <= rst_pin_nxt;
    end
  end

  // Frame settings held stable in sys domain while the frame runs
  always_comb begin
    lk_ones_nxt = lk_ones_r;
    lk_len_nxt  = lk_len_r;
    lk_byte_nxt = lk_byte_r;
    if (st_r == S_DESEL) begin
      lk_ones_nxt = (op_r == sfxr_pkg::SFXR_OP_RECOVER) || (phase_r == 2'd0 && op_r != sfxr_pkg::SFXR_OP_POLL);
      lk_len_nxt  = (op_r == sfxr_pkg::SFXR_OP_POLL) ? 6'd16 :
                    (phase_r == 2'd0) ? frame_len : `SFXR_FF_CLOCKS;
      lk_byte_nxt = cmd_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lk_len_r  <= 6'd0;
      lk_byte_r <= 8'h00;
      lk_ones_r <= 1'b1;
    end else begin
      lk_len_r  <= lk_len_nxt;
      lk_byte_r <= lk_byte_nxt;
      lk_ones_r <= lk_ones_nxt;
    end
  end

  always_ff @(posedge link_clk) begin
    sys_rst_sync0_r <= srst;
    sys_rst_sync1_r <= sys_rst_sync0_r;
  end

  // Line one lags three link clocks: device launch plus two sync stages,
  // so two tail clocks after deselect flush the last read bits in
  always_comb begin
    lk_run_nxt      = lk_run_r;
    lk_act_nxt      = lk_act_r;
    lk_cnt_nxt      = lk_cnt_r;
    lk_done_tgl_nxt = lk_done_tgl_r;
    lk_shift_nxt    = lk_shift_r;
    if (!lk_run_r && (lk_go_s2_r != lk_go_s1_r)) begin
      lk_run_nxt = 1'b1;
      lk_act_nxt = 1'b1;
      lk_cnt_nxt = 6'd0;
    end else if (lk_run_r) begin
      lk_cnt_nxt   = lk_cnt_r + 6'd1;
      lk_shift_nxt = {lk_shift_r[6:0], lk_d1_s1_r};
      if (lk_cnt_r == lk_len_r - 6'd1) begin
        lk_act_nxt = 1'b0; // Deselect before the next clock
      end
      if (lk_cnt_r == lk_len_r + 6'd1) begin
        lk_run_nxt      = 1'b0;
        lk_done_tgl_nxt = ~lk_done_tgl_r;
      end
    end
  end

  // Link domain: drive on falling edge so data is stable at device rising edge
  always_ff @(negedge link_clk) begin
    lk_d1_s0_r <= dq1_in;
    lk_d1_s1_r <= lk_d1_s0_r;
    lk_go_s0_r <= go_tgl_r;
    lk_go_s1_r <= lk_go_s0_r;
    if (sys_rst_sync1_r) begin
      lk_go_s2_r    <= 1'b0;
      lk_cnt_r      <= 6'd0;
      lk_run_r      <= 1'b0;
      lk_act_r      <= 1'b0;
      lk_done_tgl_r <= 1'b0;
      lk_shift_r    <= 8'h00;
    end else begin
      lk_go_s2_r    <= lk_go_s1_r;
      lk_cnt_r      <= lk_cnt_nxt;
      lk_run_r      <= lk_run_nxt;
      lk_act_r      <= lk_act_nxt;
      lk_done_tgl_r <= lk_done_tgl_nxt;
      lk_shift_r    <= lk_shift_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    dn_s0_r <= lk_done_tgl_r;
    dn_s1_r <= dn_s0_r;
    dn_s2_r <= dn_s1_r;
  end
  // Shift register is static once the done toggle has crossed
  assign rd_byte = lk_shift_r;

  always_comb begin
    pins.sel_n = ~lk_act_r;
    pins.rst_n = rst_pin_r;
    pins.dq_oe = 4'b1001;
    pins.dq_o  = 4'b1001;
    if (!lk_ones_r) begin
      pins.dq_o[0] = (lk_cnt_r < 6'd8) ? lk_byte_r[3'(7 - lk_cnt_r[2:0])] : 1'b1;
    end
  end

  assign sclk_en      = lk_act_r;
  assign req_ready    = (st_r == S_IDLE);
  assign stat.busy    = (st_r != S_IDLE) && (st_r != S_PWRUP);
  assign stat.done    = done_r;
  assign stat.ready   = ok_r;
  assign stat.pwr_ok  = pwr_ok_r;
endmodule

// File: sfxr_ctrl_chk.sv
`timescale 1ns/10ps
module sfxr_ctrl_chk (
  // Watched ports
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire logic                    link_clk,
  input wire sfxr_pkg::sfxr_req_type  req,
  input wire logic                    req_ready,
  input wire sfxr_pkg::sfxr_stat_type stat,
  input wire sfxr_pkg::sfxr_pins_type pins,
  input wire logic                    sclk_en,
  input wire logic                    dq1_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_sel_pwrup: assert property (!stat.pwr_ok |-> pins.sel_n) else $error("selected in power-up");
  a_rst_desel: assert property (!pins.rst_n |-> pins.sel_n) else $error("reset while selected");
  a_rst_width: assert property ($fell(pins.rst_n) |-> (!pins.rst_n)[*4] ##1 pins.rst_n) else $error("rst width");
  a_sclk_frame: assert property (@(posedge link_clk) sclk_en |-> !pins.sel_n) else $error("clock outside frame");
  a_line_oe: assert property (@(posedge link_clk) !pins.sel_n |-> pins.dq_oe == 4'h9) else $error("line enables");
  a_hold_high: assert property (@(posedge link_clk) !pins.sel_n |-> pins.dq_o[3]) else $error("line three low");
  // Longest order is some 240 link clocks, well inside the bound
  a_done_bound: assert property ($rose(stat.busy) |-> ##[1:1000] stat.done) else $error("no done");
  a_ready_pwr: assert property (req_ready |-> stat.pwr_ok) else $error("ready too early");
  c_recover: cover property (req.valid && req_ready && req.op == sfxr_pkg::SFXR_OP_RECOVER);
  c_poll_ok: cover property (stat.done && stat.ready);
  c_hw_rst: cover property ($fell(pins.rst_n));
endmodule
bind sfxr_ctrl sfxr_ctrl_chk u_chk (.sys_clk(sys_clk), .srst(srst), .link_clk(link_clk), .req(req),
  .req_ready(req_ready), .stat(stat), .pins(pins), .sclk_en(sclk_en), .dq1_in(dq1_in));

// File: sfxr_flash_model.sv
`timescale 1ns/10ps
module sfxr_flash_model (
  // Link
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic [3:0] dq,
  input  wire logic       rst_n,
  output      logic       dq1,
  // State for the bench
  input  wire logic       op_done,
  output      logic       execute_in_place_mode = 1'h1,
  output      logic       quad = 1'h1,
  output      int         n_swrst = 0
);
  int         clks = 0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] op = 8'h00;
  logic       rst_en = 1'h0;
  logic       por = 1'h1;
  logic       pwr_up = 1'h1;
  initial dq1 = 1'h0;
  // Power-on reset, then a phase that takes flag reads and the clock-seven exit only
  initial begin
    #100 por = 1'h0;
    #100 pwr_up = 1'h0;
  end
  // Quad address is six clocks, so clock seven is the first dummy
  always @(posedge sclk) begin
    if (!por) begin
      clks = clks + 1;
      cmd = {cmd[6:0], dq[0]};
      if (clks == 8)
        op = cmd;
      if (execute_in_place_mode && clks == 7 && dq[0])
        execute_in_place_mode = 1'h0;
    end
  end
  // Idle line toggles so a stale level cannot pass; updated after the host samples
  always @(negedge sclk)
    dq1 <= (!execute_in_place_mode && op == 8'h70 && clks >= 8 && clks < 16) ? (clks == 8 && op_done) : ~dq1;
  always @(posedge sel_n) begin
    if (!execute_in_place_mode && clks == 8 && !pwr_up) begin
      if (cmd == 8'h99 && rst_en)
        n_swrst = n_swrst + 1;
      if (cmd == 8'hff)
        quad = 1'h0;
      rst_en = (cmd == 8'h66);
    end
    clks = 0;
    op = 8'h00;
  end
  always @(negedge rst_n)
    if (sel_n) begin
      execute_in_place_mode = 1'h1;
      quad = 1'h1;
    end
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    logic [1:0] op;
    logic       fin;
    logic       execute_in_place_mode;
    logic       quad;
    logic [1:0] sw;
    logic       rdy;
  } sfxr_row_type;
  logic                    sys_clk;
  logic                    link_clk;
  logic                    srst;
  logic                    req_ready;
  logic                    sclk_en;
  logic                    dq1;
  logic                    fin;
  logic                    execute_in_place_mode;
  logic                    quad;
  int                      n_swrst;
  int                      err_total = 0;
  int                      n_tests = 0;
  int                      cyc = 0;
  sfxr_pkg::sfxr_req_type  req;
  sfxr_pkg::sfxr_stat_type stat;
  sfxr_pkg::sfxr_pins_type pins;
  sfxr_row_type rows [7] = '{'{2'h0, 1'h1, 1'h0, 1'h1, 2'h1, 1'h0}, '{2'h2, 1'h1, 1'h0, 1'h1, 2'h1, 1'h1},
    '{2'h2, 1'h0, 1'h0, 1'h1, 2'h1, 1'h0}, '{2'h3, 1'h1, 1'h1, 1'h1, 2'h1, 1'h0},
    '{2'h1, 1'h1, 1'h0, 1'h0, 2'h1, 1'h0}, '{2'h3, 1'h1, 1'h1, 1'h1, 2'h1, 1'h0},
    '{2'h0, 1'h1, 1'h0, 1'h1, 2'h2, 1'h0}};
  sfxr_ctrl #(.PWRUP_CYC(20)) uut (.sys_clk(sys_clk), .srst(srst), .link_clk(link_clk), .req(req),
    .req_ready(req_ready), .stat(stat), .pins(pins), .sclk_en(sclk_en), .dq1_in(dq1));
  sfxr_flash_model u_flash (.sclk(link_clk & sclk_en), .sel_n(pins.sel_n), .dq(pins.dq_o), .rst_n(pins.rst_n),
    .dq1(dq1), .op_done(fin), .execute_in_place_mode(execute_in_place_mode), .quad(quad), .n_swrst(n_swrst));
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'h0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic run(input sfxr_pkg::sfxr_op_type op);
    int i;
    req = '{valid: 1'h1, op: op};
    for (i = 0; i < 100 && req_ready !== 1'h1; i++)
      @(negedge sys_clk);
    chk("req_ready", 1'h1, req_ready);
    @(negedge sys_clk);
    req.valid = 1'h0;
    for (i = 0; i < 3000 && stat.done !== 1'h1; i++)
      @(negedge sys_clk);
    chk("done", 1'h1, stat.done);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    srst = 1'h1;
    fin = 1'h1;
    req = '{valid: 1'h0, op: sfxr_pkg::SFXR_OP_XIP_EXIT};
    repeat (8) @(negedge sys_clk);
    chk("sel_n", 1'h1, pins.sel_n);
    chk("rst_n", 1'h1, pins.rst_n);
    srst = 1'h0;
    // Order held in the power-up wait is dropped
    req.valid = 1'h1;
    repeat (10) @(negedge sys_clk);
    chk("ready", 1'h0, req_ready);
    req.valid = 1'h0;
    repeat (30) @(negedge sys_clk);
    chk("xip", 1'h1, execute_in_place_mode);
    foreach (rows[i]) begin
      fin = rows[i].fin;
      run(sfxr_pkg::sfxr_op_type'(rows[i].op));
      chk("xip", rows[i].execute_in_place_mode, execute_in_place_mode);
      chk("quad", rows[i].quad, quad);
      chk("swrst", rows[i].sw, n_swrst);
      if (rows[i].op == 2'h2)
        chk("ready", rows[i].rdy, stat.ready);
    end
    // Reset in mid-recovery, then recover whole
    run(sfxr_pkg::SFXR_OP_HW_RESET);
    req = '{valid: 1'h1, op: sfxr_pkg::SFXR_OP_RECOVER};
    repeat (30) @(negedge sys_clk);
    srst = 1'h1;
    req.valid = 1'h0;
    repeat (8) @(negedge sys_clk);
    chk("sel_n", 1'h1, pins.sel_n);
    srst = 1'h0;
    run(sfxr_pkg::SFXR_OP_RECOVER);
    chk("xip", 1'h0, execute_in_place_mode);
    chk("quad", 1'h0, quad);
    report_and_stop();
  end
endmodule
